// ---- rtl/bsx_pkg.sv ----
// Shared opcodes, addresses, field positions, reset values and carrier types of the executor.
package bsx_pkg;
  // Opcodes; register forms keep the low three bits as the register index.
  localparam logic [7:0] OP_SET_CARRY = 8'hD3;
  localparam logic [7:0] OP_SET_BIT = 8'hD2;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] OP_SUB_IMM = 8'h94;
  localparam logic [7:0] OP_SUB_DIR = 8'h95;
  localparam logic [7:0] OP_SWAP = 8'hC4;
  localparam logic [7:0] OP_XCH_DIR = 8'hC5;
  localparam logic [7:0] OP_XOR_IMM = 8'h64;
  localparam logic [7:0] OP_XOR_DIR = 8'h65;
  localparam logic [7:0] OP_XOR_TO_DIR = 8'h62;
  localparam logic [7:0] OP_XOR_MASK_DIR = 8'h63;
  // Direct addresses that live inside the executor, and the base of the bit-addressable memory.
  localparam logic [7:0] ADDR_ACC = 8'hE0;
  localparam logic [7:0] ADDR_PSW = 8'hD0;
  localparam logic [7:0] ADDR_PORT = 8'h90;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  // Status word field positions.
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV = 2;
  // Reset values.
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  // Program counter step taken before a relative displacement is added.
  localparam logic [15:0] SHORT_JUMP_STEP = 16'h0002;

  // One write into the external data space.
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } bsx_mem_wr_type;

  // Whole state of the executor.
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] acc;
    logic [7:0] psw;
    logic [7:0] portLatch;
    logic [7:0] pinMeta;
    logic [7:0] pinSync;
    logic stall;
  } bsx_state_type;
endpackage

// ---- rtl/bsx_exec.sv ----
// Executor for the bit set, short jump, subtract, swap, exchange and xor instruction group.

module bsx_exec (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Program memory, three bytes starting at codeAddr, combinational
  output logic [15:0] codeAddr,
  input wire logic [23:0] codeBytes,
  // Data space read port A, register or pointer fetch, combinational
  output logic [7:0] rdAddrA,
  input wire logic [7:0] rdDataA,
  // Data space read port B, operand fetch, combinational
  output logic [7:0] rdAddrB,
  input wire logic [7:0] rdDataB,
  // Data space write strobe
  output bsx_pkg::bsx_mem_wr_type memWr,
  // Output port
  input wire logic [7:0] portPins,
  output logic [7:0] portOut,
  // Status
  output logic [7:0] accOut,
  output logic [7:0] pswOut,
  output logic illegalOp
);
  import bsx_pkg::*;

  localparam bsx_state_type ST_RESET = '{pc: PC_RESET, acc: ACC_RESET, psw: PSW_RESET,
    portLatch: PORT_RESET, pinMeta: PORT_RESET, pinSync: PORT_RESET, stall: 1'b0};

  bsx_state_type st;
  bsx_state_type next_st;
  logic [7:0] op;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] src;
  logic [7:0] subRes;
  logic [8:0] d9;
  logic [7:0] d7;
  logic [4:0] d4;
  logic [15:0] jumpPc;
  logic [1:0] len;
  logic twoCycle;
  logic commit;
  logic indirect;
  logic dEn;
  logic [7:0] dAddr;
  logic [7:0] dData;

  assign {b2, b1, op} = codeBytes;

  // Reads of the executor's own locations; a read-modify-write sees the port latch.
  function automatic logic [7:0] sfrRead(input logic [7:0] a, input logic rmw,
                                         input bsx_state_type s, input logic [7:0] mem);
    logic [7:0] v;
    v = mem;
    if (a == ADDR_ACC) begin
      v = s.acc;
    end else if (a == ADDR_PSW) begin
      v = s.psw;
    end else if (a == ADDR_PORT) begin
      v = rmw ? s.portLatch : s.pinSync;
    end
    return v;
  endfunction

  // Byte that holds an addressable bit.
  function automatic logic [7:0] bitByte(input logic [7:0] b);
    return b[7] ? {b[7:3], 3'b000} : (BIT_RAM_BASE | {4'h0, b[6:3]});
  endfunction

  // Port A fetches the bank register named by the opcode: Rn, or pointer Ri for indirect forms.
  always_comb begin
    indirect = (op[3:1] == 3'b011);
    if (op[3]) begin
      rdAddrA = {3'b000, st.psw[PSW_RS1:PSW_RS0], op[2:0]};
    end else begin
      rdAddrA = {3'b000, st.psw[PSW_RS1:PSW_RS0], 2'b00, op[0]};
    end
    if (indirect) begin
      rdAddrB = rdDataA;
    end else if (op == OP_SET_BIT) begin
      rdAddrB = bitByte(b1);
    end else begin
      rdAddrB = b1;
    end
  end

  // Source operand by addressing form, then the subtract arithmetic and its borrows.
  always_comb begin
    if (op[3]) begin
      src = rdDataA;
    end else if (indirect) begin
      src = rdDataB;
    end else if (op[0]) begin
      src = sfrRead(b1, 1'b0, st, rdDataB);
    end else begin
      src = b1;
    end
    d9 = {1'b0, st.acc} - {1'b0, src} - {8'h00, st.psw[PSW_CY]};
    d7 = {1'b0, st.acc[6:0]} - {1'b0, src[6:0]} - {7'h00, st.psw[PSW_CY]};
    d4 = {1'b0, st.acc[3:0]} - {1'b0, src[3:0]} - {4'h0, st.psw[PSW_CY]};
    subRes = d9[7:0];
    jumpPc = st.pc + SHORT_JUMP_STEP + {{8{b1[7]}}, b1};
  end

  // Decode and execute. Two-cycle forms spend their first cycle stalled with the pc held,
  // so the program memory keeps presenting the same bytes.
  always_comb begin
    next_st = st;
    next_st.pinMeta = portPins;
    next_st.pinSync = st.pinMeta;
    illegalOp = 1'b0;
    len = 2'd1;
    twoCycle = 1'b0;
    dEn = 1'b0;
    dAddr = b1;
    dData = 8'h00;
    memWr = '0;
    unique casez (op)
      OP_SET_CARRY: begin
        next_st.psw[PSW_CY] = 1'b1;
      end
      OP_SET_BIT: begin
        len = 2'd2;
        dEn = 1'b1;
        dAddr = bitByte(b1);
        dData = sfrRead(dAddr, 1'b1, st, rdDataB) | (8'h01 << b1[2:0]);
      end
      OP_SHORT_JUMP: begin
        twoCycle = 1'b1;
      end
      8'b1001_1???, 8'b1001_011?, OP_SUB_DIR, OP_SUB_IMM: begin
        len = (op[3] || indirect) ? 2'd1 : 2'd2;
        next_st.acc = subRes;
        next_st.psw[PSW_CY] = d9[8];
        next_st.psw[PSW_AC] = d4[4];
        next_st.psw[PSW_OV] = d7[7] ^ d9[8];
      end
      OP_SWAP: begin
        next_st.acc = {st.acc[3:0], st.acc[7:4]};
      end
      8'b1100_1???, 8'b1100_011?: begin
        next_st.acc = src;
        memWr = '{en: 1'b1, addr: op[3] ? rdAddrA : rdAddrB, data: st.acc};
      end
      OP_XCH_DIR: begin
        len = 2'd2;
        next_st.acc = src;
        dEn = 1'b1;
        dData = st.acc;
      end
      8'b1101_011?: begin
        next_st.acc = {st.acc[7:4], rdDataB[3:0]};
        memWr = '{en: 1'b1, addr: rdAddrB, data: {rdDataB[7:4], st.acc[3:0]}};
      end
      8'b0110_1???, 8'b0110_011?, OP_XOR_DIR, OP_XOR_IMM: begin
        len = (op[3] || indirect) ? 2'd1 : 2'd2;
        next_st.acc = st.acc ^ src;
      end
      OP_XOR_TO_DIR: begin
        len = 2'd2;
        dEn = 1'b1;
        dData = sfrRead(b1, 1'b1, st, rdDataB) ^ st.acc;
      end
      OP_XOR_MASK_DIR: begin
        len = 2'd3;
        twoCycle = 1'b1;
        dEn = 1'b1;
        dData = sfrRead(b1, 1'b1, st, rdDataB) ^ b2;
      end
      default: begin
        // Opcodes outside this group are skipped as one byte and flagged.
        illegalOp = 1'b1;
      end
    endcase
    commit = !(twoCycle && !st.stall);
    if (!commit) begin
      next_st.acc = st.acc;
      next_st.psw = st.psw;
      next_st.stall = 1'b1;
      memWr = '0;
      dEn = 1'b0;
      illegalOp = 1'b0;
    end else begin
      next_st.stall = 1'b0;
      next_st.pc = (op == OP_SHORT_JUMP) ? jumpPc : st.pc + {14'h0000, len};
    end
    // A direct write lands inside the executor or goes out on the write strobe.
    if (dEn) begin
      if (dAddr == ADDR_ACC) begin
        next_st.acc = dData;
      end else if (dAddr == ADDR_PSW) begin
        next_st.psw = dData;
      end else if (dAddr == ADDR_PORT) begin
        next_st.portLatch = dData;
      end else begin
        memWr = '{en: 1'b1, addr: dAddr, data: dData};
      end
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign codeAddr = st.pc;
  assign accOut = st.acc;
  assign pswOut = st.psw;
  assign portOut = st.portLatch;

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_bit_set_op_carry_only: assert property (commit && op == OP_SET_CARRY |=>
    st.psw == ($past(st.psw) | 8'h80) && $stable(st.acc))
    else $error("carry set changed other state");
  a_bit_set_op_bit_step: assert property (commit && op == OP_SET_BIT && b1 < 8'h80 |->
    memWr.en && memWr.data[b1[2:0]] ##1 st.pc == $past(st.pc) + 16'h0002)
    else $error("bit set wrong write or length");
  a_short_rel_jump_two_cycle: assert property (!st.stall && op == OP_SHORT_JUMP |=>
    st.stall && $stable(st.pc) ##1 st.pc == $past(jumpPc) && !st.stall)
    else $error("short jump timing or target wrong");
  a_sub_with_borrow_carry_out: assert property (commit && op[7:4] == 4'h9 && !illegalOp |=>
    st.psw[PSW_CY] == ({1'b0, $past(st.acc)} < ({1'b0, $past(src)} + {8'h00, $past(st.psw[PSW_CY])})))
    else $error("subtract carry wrong");
  a_sub_with_borrow_nibble_flag: assert property (commit && op[7:4] == 4'h9 && !illegalOp |=>
    st.psw[PSW_AC] == ({1'b0, $past(st.acc[3:0])} <
    ({1'b0, $past(src[3:0])} + {4'h0, $past(st.psw[PSW_CY])})))
    else $error("subtract nibble carry wrong");
  a_sub_with_borrow_wrap_flag: assert property (commit && op[7:4] == 4'h9 && !illegalOp |=>
    st.psw[PSW_OV] == (($past(st.acc[7]) != $past(src[7])) && (st.acc[7] != $past(st.acc[7]))))
    else $error("subtract wrap flag wrong");
  a_sub_with_borrow_acc_value: assert property (commit && op[7:4] == 4'h9 && !illegalOp |=>
    st.acc + $past(src) + {7'h00, $past(st.psw[PSW_CY])} == $past(st.acc))
    else $error("subtract result wrong");
  a_swap_nibbles: assert property (commit && op == OP_SWAP |=>
    st.acc == {$past(st.acc[3:0]), $past(st.acc[7:4])} && $stable(st.psw))
    else $error("swap wrong");
  a_xch_both_ways: assert property (commit && op[7:3] == 5'b11001 |->
    memWr.en && memWr.addr == rdAddrA && memWr.data == st.acc ##1 st.acc == $past(rdDataA))
    else $error("register exchange wrong");
  a_digit_exchange_low_digit: assert property (commit && op[7:1] == 7'b1101011 |=>
    st.acc[7:4] == $past(st.acc[7:4]) && st.acc[3:0] == $past(rdDataB[3:0]) && $stable(st.psw))
    else $error("digit exchange wrong");
  a_xrl_port_latch: assert property (st.stall && op == OP_XOR_MASK_DIR && b1 == ADDR_PORT |=>
    st.portLatch == ($past(st.portLatch) ^ $past(b2)) && st.pc == $past(st.pc) + 16'h0003)
    else $error("xor to port did not use latch");
  a_xrl_acc_reg: assert property (commit && op[7:3] == 5'b01101 |=>
    st.acc == ($past(st.acc) ^ $past(rdDataA)) && $stable(st.psw)
    && st.pc == $past(st.pc) + 16'h0001)
    else $error("xor into accumulator wrong");

  // A skipped opcode must not disturb anything, or a stray byte would corrupt the program.
  a_illegal_skip: assert property (illegalOp |-> !memWr.en ##1
    st.pc == $past(st.pc) + 16'h0001 && $stable(st.acc) && $stable(st.psw)
    && $stable(st.portLatch))
    else $error("skipped opcode changed state");

  // Direct and immediate subtracts carry one operand byte and never stall.
  a_sub_with_borrow_two_bytes: assert property (commit && (op == OP_SUB_DIR || op == OP_SUB_IMM) |=>
    st.pc == $past(st.pc) + 16'h0002 && !st.stall)
    else $error("subtract length wrong");

  // Direct exchange into plain memory writes the old accumulator and loads the old byte.
  a_xch_dir_both: assert property (commit && op == OP_XCH_DIR && !b1[7] |->
    memWr.en && memWr.addr == b1 && memWr.data == st.acc
    ##1 st.acc == $past(rdDataB) && st.pc == $past(st.pc) + 16'h0002)
    else $error("direct exchange wrong");

  // The digit exchange writes back the memory byte with only its low nibble replaced.
  a_digit_exchange_mem_side: assert property (commit && op[7:1] == 7'b1101011 |->
    memWr.en && memWr.addr == rdAddrB && memWr.data == {rdDataB[7:4], st.acc[3:0]})
    else $error("digit exchange memory side wrong");

  // Xor into a memory byte goes out on the strobe and leaves accumulator and flags alone.
  a_xrl_to_dir_ram: assert property (commit && op == OP_XOR_TO_DIR && !b1[7] |->
    memWr.en && memWr.addr == b1 && memWr.data == (rdDataB ^ st.acc)
    ##1 st.pc == $past(st.pc) + 16'h0002 && $stable(st.psw) && $stable(st.acc))
    else $error("xor to direct wrong");

  // The mask form must not write in its stall cycle, or the destination would flip twice.
  a_xrl_mask_stall: assert property (!st.stall && op == OP_XOR_MASK_DIR |-> !memWr.en ##1
    st.stall && $stable(st.pc) && $stable(st.portLatch))
    else $error("mask xor wrote in its first cycle");
endmodule // bsx_exec

// ---- tb/tb_top.sv ----
// Self-checking bench for the bit set, jump, subtract, swap, exchange and xor executor.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bsx_pkg::*;
  // Clock, reset and the nets that face the executor.
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] portPins = 8'h00;
  logic [15:0] codeAddr;
  logic [23:0] codeBytes;
  logic [7:0] rdAddrA, rdDataA, rdAddrB, rdDataB, portOut, accOut, pswOut;
  logic illegalOp;
  bsx_mem_wr_type memWr;
  logic [7:0] prog [256];
  logic [7:0] dmem [256];
  int errorCnt = 0;
  int samplesChecked = 0;

  // Free-running clock at 125 MHz.
  always #4 mclk = ~mclk;

  // Program and data memories answer in the same cycle, as the executor expects.
  assign codeBytes = {prog[codeAddr[7:0] + 8'h02], prog[codeAddr[7:0] + 8'h01], prog[codeAddr[7:0]]};
  assign rdDataA = dmem[rdAddrA];
  assign rdDataB = dmem[rdAddrB];

  // Data writes land at the edge that ends the strobe cycle.
  always @(posedge mclk) begin
    if (memWr.en === 1'b1) begin
      dmem[memWr.addr] <= memWr.data;
    end
  end

  bsx_exec DUT (
    .mclk(mclk), .sys_rst(sys_rst), .codeAddr(codeAddr), .codeBytes(codeBytes),
    .rdAddrA(rdAddrA), .rdDataA(rdDataA), .rdAddrB(rdAddrB), .rdDataB(rdDataB),
    .memWr(memWr), .portPins(portPins), .portOut(portOut), .accOut(accOut),
    .pswOut(pswOut), .illegalOp(illegalOp)
  );

  // Byte, word and bit comparisons; case equality keeps unknowns from matching.
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samplesChecked++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    samplesChecked++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    samplesChecked++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Loads twelve program bytes from the top of v, resets, then clears data memory.
  task automatic start(input logic [95:0] v);
    @(negedge mclk);
    sys_rst = 1'b1;
    for (int i = 0; i < 256; i++) begin
      prog[i] = (i < 12) ? v[95 - 8 * i -: 8] : 8'h00;
    end
    repeat (20) @(negedge mclk);
    for (int i = 0; i < 256; i++) begin
      dmem[i] = 8'h00;
    end
    sys_rst = 1'b0;
  endtask

  task automatic run(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Mask xor on the port while pins read low, then carry and bit sets.
  task automatic t_bit_set_op();
    start(96'h6390CB_D3_D290_D200_00000000);
    dmem[8'h20] = 8'h40;
    run(5);
    chk8("portOut", 8'h35, portOut);
    chk8("pswOut", 8'h80, pswOut);
    chk8("ram20", 8'h41, dmem[8'h20]);
    chk16("pc", 16'h0008, codeAddr);
  endtask

  // Forward jump, then a backward one that wraps below zero.
  task automatic t_short_rel_jump();
    start(96'h8021_0000_0000_0000_0000_0000);
    prog[8'h23] = 8'h80;
    prog[8'h24] = 8'h80;
    run(1);
    chk16("pcStall", 16'h0000, codeAddr);
    run(1);
    chk16("pcFwd", 16'h0023, codeAddr);
    run(2);
    chk16("pcBack", 16'hFFA5, codeAddr);
  endtask

  // Subtract chain over every source form, flags checked after each step.
  task automatic t_sub_with_borrow();
    start(96'h64C9_D3_9A_9475_9530_97_000000);
    dmem[8'h02] = 8'h54;
    dmem[8'h30] = 8'h7F;
    dmem[8'h01] = 8'h40;
    dmem[8'h40] = 8'h80;
    run(3);
    chk8("acc", 8'h74, accOut);
    chk8("psw", 8'h04, pswOut);
    run(1);
    chk8("acc", 8'hFF, accOut);
    chk8("psw", 8'hC0, pswOut);
    run(1);
    chk8("acc", 8'h7F, accOut);
    chk8("psw", 8'h44, pswOut);
    run(1);
    chk8("acc", 8'hFF, accOut);
    chk8("psw", 8'h84, pswOut);
    chk16("pc", 16'h0009, codeAddr);
  endtask

  // Swap, exchange through a pointer and a bank-one register, then digit exchange.
  task automatic t_xch();
    start(96'h64C5_D3_C4_C6_D2D3_CB_D7_000000);
    dmem[8'h00] = 8'h20;
    dmem[8'h20] = 8'h75;
    dmem[8'h0B] = 8'h11;
    dmem[8'h09] = 8'h21;
    dmem[8'h21] = 8'h76;
    run(7);
    chk8("ram20", 8'h5C, dmem[8'h20]);
    chk8("ram0B", 8'h75, dmem[8'h0B]);
    chk8("ram21", 8'h71, dmem[8'h21]);
    chk8("acc", 8'h16, accOut);
    chk8("psw", 8'h88, pswOut);
  endtask

  // Xor in every accumulator form and both direct-destination forms.
  task automatic t_xrl();
    start(96'h64C3_68_6530_67_6231_6332F0_00);
    dmem[8'h00] = 8'hAA;
    dmem[8'h30] = 8'h0F;
    dmem[8'h01] = 8'h40;
    dmem[8'h40] = 8'hFF;
    dmem[8'h31] = 8'h33;
    dmem[8'h32] = 8'h12;
    run(2);
    chk8("acc", 8'h69, accOut);
    run(2);
    chk8("acc", 8'h99, accOut);
    run(3);
    chk8("ram31", 8'hAA, dmem[8'h31]);
    chk8("ram32", 8'hE2, dmem[8'h32]);
    chk8("psw", 8'h00, pswOut);
    chk16("pc", 16'h000B, codeAddr);
  endtask

  // Skipped bytes, a direct read of the synchronised pins, then xor back through the latch.
  task automatic t_pins();
    start(96'h0000_6590_6290_0000_0000_0000);
    portPins = 8'h3C;
    run(1);
    chk1("illegalOp", 1'b1, illegalOp);
    chk16("pcSkip", 16'h0001, codeAddr);
    run(2);
    chk8("acc", 8'h3C, accOut);
    chk1("illegalOp", 1'b0, illegalOp);
    run(1);
    chk8("portOut", 8'hC3, portOut);
    chk16("pc", 16'h0006, codeAddr);
  endtask

  // Main sequence.
  initial begin
    t_bit_set_op();
    t_short_rel_jump();
    t_sub_with_borrow();
    t_xch();
    t_xrl();
    t_pins();
    final_report();
  end

  // Watchdog; the whole run needs about 160 cycles, well under two thousand.
  initial begin
    repeat (2000) @(posedge mclk);
    errorCnt++;
    final_report();
  end
endmodule // tb_top
